// ### verilog/pcc_pkg.sv
package pcc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CNT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CCAP = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_KICK = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_MSEL = 4'h7;

  localparam logic [3:0] DIV_SYS12 = 4'hb;
  localparam logic [3:0] DIV_SYS4 = 4'h3;
  localparam logic [3:0] DIV_EXT8 = 4'h7;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  localparam int NMOD = 6;
  localparam int WD_MOD = 5;
  localparam logic [15:0] WD_LIMIT_RST = 16'hffff;
  localparam logic [31:0] KICK_KEY = 32'h000000a5;

  typedef enum logic [2:0] {
    SRC_SYS12, SRC_SYS4, SRC_T0OVF, SRC_EXTCNT, SRC_SYS, SRC_EXT8
  } pcc_src_t;

  typedef enum logic [2:0] {
    MD_OFF, MD_CAPTURE, MD_SWTIMER, MD_HSOUT, MD_PWM8, MD_PWM16, MD_FREQ,
    MD_WATCHDOG
  } pcc_mode_t;

  typedef struct packed {
    logic       run;
    pcc_src_t   src;
  } pcc_ctrl_t;

  typedef struct packed {
    logic       t0Ovf;
    logic       extCount;
    logic       extOsc;
  } pcc_tick_in_t;
endpackage

// ### verilog/pcc_tick_gen.sv
module pcc_tick_gen (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire pcc_pkg::pcc_src_t     src,
  input  wire pcc_pkg::pcc_tick_in_t tin,
  output logic                       tick
);
  pcc_pkg::pcc_src_t src_r;
  logic [3:0] div_r, div_nxt, div;
  logic [2:0] hist_r, hist_nxt;
  logic [2:0] rise;
  logic       tick_nxt;

  always_comb begin
    hist_nxt = {tin.t0Ovf, tin.extCount, tin.extOsc};
    rise = hist_nxt & ~hist_r;
    // A source change restarts the divider so no early tick follows.
    div = (src == src_r) ? div_r : 4'h0;
    div_nxt = div;
    tick_nxt = 1'b0;
    case (src)
      pcc_pkg::SRC_SYS12: begin
        tick_nxt = (div == pcc_pkg::DIV_SYS12);
        div_nxt = tick_nxt ? 4'h0 : div + 4'h1;
      end
      pcc_pkg::SRC_SYS4: begin
        tick_nxt = (div >= pcc_pkg::DIV_SYS4);
        div_nxt = tick_nxt ? 4'h0 : div + 4'h1;
      end
      pcc_pkg::SRC_T0OVF: tick_nxt = rise[2];
      pcc_pkg::SRC_EXTCNT: tick_nxt = rise[1];
      pcc_pkg::SRC_SYS: tick_nxt = 1'b1;
      pcc_pkg::SRC_EXT8: begin
        if (rise[0]) begin
          tick_nxt = (div >= pcc_pkg::DIV_EXT8);
          div_nxt = tick_nxt ? 4'h0 : div + 4'h1;
        end
      end
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_r <= pcc_pkg::SRC_SYS12;
      div_r <= 4'h0;
      hist_r <= 3'h0;
      tick <= 1'b0;
    end else if (ce) begin
      src_r <= src;
      div_r <= div_nxt;
      hist_r <= hist_nxt;
      tick <= tick_nxt;
    end
  end
endmodule

// ### verilog/pcc_module.sv
module pcc_module #(
  parameter logic [2:0] RST_MODE = 3'h0
) (
  input  wire logic                mclk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  input  wire logic                tick,
  input  wire logic [15:0]         cnt,
  input  wire logic                capIn,
  input  wire logic                modeWe,
  input  wire pcc_pkg::pcc_mode_t  modeIn,
  input  wire logic                capWe,
  input  wire logic [15:0]         capWr,
  output pcc_pkg::pcc_mode_t       mode,
  output logic [15:0]              capVal,
  output logic                     pinOut,
  output logic                     event_
);
  pcc_pkg::pcc_mode_t mode_nxt;
  logic [15:0] cap_nxt;
  logic        capIn_r, pin_nxt, ev_nxt;
  logic [7:0]  fcnt_r, fcnt_nxt;

  always_comb begin
    mode_nxt = modeWe ? modeIn : mode;
    cap_nxt = capWe ? capWr : capVal;
    pin_nxt = pinOut;
    ev_nxt = 1'b0;
    fcnt_nxt = fcnt_r;
    case (mode)
      pcc_pkg::MD_CAPTURE: begin
        if (capIn && !capIn_r) begin
          cap_nxt = cnt;
          ev_nxt = 1'b1;
        end
      end
      pcc_pkg::MD_SWTIMER: ev_nxt = tick && (cnt == capVal);
      pcc_pkg::MD_HSOUT: begin
        if (tick && cnt == capVal) begin
          ev_nxt = 1'b1;
          pin_nxt = ~pinOut;
        end
      end
      pcc_pkg::MD_PWM8: pin_nxt = (cnt[7:0] >= capVal[15:8]);
      pcc_pkg::MD_PWM16: pin_nxt = (cnt >= capVal);
      pcc_pkg::MD_FREQ: begin
        if (tick) begin
          fcnt_nxt = fcnt_r + 8'h01;
          if (fcnt_nxt == capVal[15:8]) begin
            fcnt_nxt = 8'h00;
            pin_nxt = ~pinOut;
          end
        end
      end
      pcc_pkg::MD_WATCHDOG: ev_nxt = tick && (cnt == capVal);
      default: pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= pcc_pkg::pcc_mode_t'(RST_MODE);
      capVal <= pcc_pkg::WD_LIMIT_RST;
      capIn_r <= 1'b0;
      pinOut <= 1'b0;
      event_ <= 1'b0;
      fcnt_r <= 8'h00;
    end else if (ce) begin
      mode <= mode_nxt;
      capVal <= cap_nxt;
      capIn_r <= capIn;
      pinOut <= pin_nxt;
      event_ <= ev_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end
endmodule

// ### verilog/pcc_top.sv
// Operation
// [R1] Dedicated sixteen bit shared time base counter.
// [R2] Six selectable time base clock sources.
// [R3] Each module runs one of six modes.
// [R4] Module five also offers watchdog function.
// [R5] Reset starts module five as enabled watchdog.
// [R6] Module pins and count input reach crossbar.
// [R7] External oscillator source counts independently; here its edges are sampled on mclk and divided by eight.
// [R8] Wrap sets overflow flag, may interrupt.
module pcc_top #(
  parameter int NMOD = pcc_pkg::NMOD
) (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  t0Ovf,
  input  wire logic                  externalCountInput,
  input  wire logic                  extOscClk,
  input  wire logic [NMOD-1:0]       capPin,
  output logic [NMOD-1:0]            cmpPin,
  output logic                       irq,
  output logic                       watchdogReset
);
  pcc_pkg::pcc_ctrl_t     ctrl_r, ctrl_nxt;
  logic [15:0]            cnt_r, cnt_nxt;
  logic [NMOD:0]          stat_r, stat_nxt;
  logic [NMOD:0]          mask_r, mask_nxt;
  logic [2:0]             msel_r, msel_nxt;
  logic [31:0]            rd_nxt;
  logic                   ack_nxt, irq_nxt, wdr_nxt;
  logic                   tick, acc, wr, wrLo, wrHi, cntTick;
  logic                   ovf;
  pcc_pkg::pcc_tick_in_t  tin;
  pcc_pkg::pcc_mode_t     modeArr [NMOD];
  logic [15:0]            capArr  [NMOD];
  logic [NMOD-1:0]        pinArr, evArr, modeWe, capWe;
  pcc_pkg::pcc_mode_t     modeIn;
  logic [15:0]            capWr;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  assign tin = '{t0Ovf: t0Ovf, extCount: externalCountInput,
                 extOsc: extOscClk}; // [R6] [R7]
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign wrLo = wr && wb_sel_i[0];
  assign wrHi = wr && wb_sel_i[1];
  // Modules see ticks only while the counter runs, so a match on a stopped counter never fires.
  assign cntTick = tick && ctrl_r.run; // [R1]

  pcc_tick_gen u_tick (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ce     (ce),
    .src    (ctrl_r.src),
    .tin    (tin),
    .tick   (tick)
  ); // [R2] [R7]

  always_comb begin
    modeIn = pcc_pkg::pcc_mode_t'(wb_dat_i[2:0]);
    capWr = {wrHi ? wb_dat_i[15:8] : capArr[msel_r][15:8],
             wrLo ? wb_dat_i[7:0] : capArr[msel_r][7:0]};
    for (int i = 0; i < NMOD; i++) begin
      modeWe[i] = wrLo && hit(wb_adr_i, pcc_pkg::OFS_MODE)
                  && (msel_r == 3'(i))
                  && (modeIn != pcc_pkg::MD_WATCHDOG
                      || i == pcc_pkg::WD_MOD); // [R3] [R4]
      capWe[i] = (wrLo || wrHi) && hit(wb_adr_i, pcc_pkg::OFS_CCAP)
                 && (msel_r == 3'(i));
    end
  end

  for (genvar g = 0; g < NMOD; g++) begin : g_mod
    pcc_module #(
      .RST_MODE ((g == pcc_pkg::WD_MOD) ? 3'(pcc_pkg::MD_WATCHDOG)
                                        : 3'(pcc_pkg::MD_OFF))
    ) u_mod (
      .mclk   (mclk),
      .arst_n (arst_n),
      .ce     (ce),
      .tick   (cntTick),
      .cnt    (cnt_r),
      .capIn  (capPin[g]),
      .modeWe (modeWe[g]),
      .modeIn (modeIn),
      .capWe  (capWe[g]),
      .capWr  (capWr),
      .mode   (modeArr[g]),
      .capVal (capArr[g]),
      .pinOut (pinArr[g]),
      .event_ (evArr[g])
    ); // [R3] [R5] [R6]
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r;
    msel_nxt = msel_r;
    mask_nxt = mask_r;
    ovf = 1'b0;
    if (ctrl_r.run && tick) begin
      cnt_nxt = cnt_r + 16'h0001; // [R1]
      ovf = (cnt_r == pcc_pkg::CNT_MAX); // [R8]
    end
    if (hit(wb_adr_i, pcc_pkg::OFS_KICK) && wr
        && wb_dat_i == pcc_pkg::KICK_KEY) begin
      cnt_nxt = pcc_pkg::CNT_ZERO;
    end
    if (wrLo && hit(wb_adr_i, pcc_pkg::OFS_CTRL)) begin
      ctrl_nxt.run = wb_dat_i[3];
      ctrl_nxt.src = (wb_dat_i[2:0] > 3'(pcc_pkg::SRC_EXT8))
                     ? ctrl_r.src : pcc_pkg::pcc_src_t'(wb_dat_i[2:0]);
    end
    if (hit(wb_adr_i, pcc_pkg::OFS_CNT)) begin
      if (wrLo) cnt_nxt[7:0] = wb_dat_i[7:0];
      if (wrHi) cnt_nxt[15:8] = wb_dat_i[15:8];
    end
    if (wrLo && hit(wb_adr_i, pcc_pkg::OFS_MSEL)) begin
      msel_nxt = (wb_dat_i[2:0] < 3'(NMOD)) ? wb_dat_i[2:0] : msel_r;
    end
    if (wrLo && hit(wb_adr_i, pcc_pkg::OFS_MASK)) begin
      mask_nxt = wb_dat_i[NMOD:0];
    end
    stat_nxt = stat_r;
    if (wrLo && hit(wb_adr_i, pcc_pkg::OFS_STAT)) begin
      stat_nxt = stat_r & ~wb_dat_i[NMOD:0];
    end
    stat_nxt = stat_nxt | {ovf, evArr}; // [R8]
    irq_nxt = |(stat_nxt & mask_nxt); // [R8]
    wdr_nxt = evArr[pcc_pkg::WD_MOD]
              && modeArr[pcc_pkg::WD_MOD] == pcc_pkg::MD_WATCHDOG; // [R4]
    ack_nxt = acc;
    rd_nxt = 32'h0;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        pcc_pkg::OFS_CTRL: rd_nxt = {28'h0, ctrl_r.run, ctrl_r.src};
        pcc_pkg::OFS_MODE: rd_nxt = {29'h0, modeArr[msel_r]};
        pcc_pkg::OFS_CNT: rd_nxt = {16'h0, cnt_r};
        pcc_pkg::OFS_STAT: rd_nxt = 32'(stat_r);
        pcc_pkg::OFS_MASK: rd_nxt = 32'(mask_r);
        pcc_pkg::OFS_CCAP: rd_nxt = {16'h0, capArr[msel_r]};
        pcc_pkg::OFS_MSEL: rd_nxt = {29'h0, msel_r};
        default: rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= '{run: 1'b1, src: pcc_pkg::SRC_SYS12}; // [R5]
      cnt_r <= pcc_pkg::CNT_ZERO;
      stat_r <= '0;
      mask_r <= '0;
      msel_r <= 3'h0;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      irq <= 1'b0;
      watchdogReset <= 1'b0;
      cmpPin <= '0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      msel_r <= msel_nxt;
      wb_dat_o <= rd_nxt;
      wb_ack_o <= ack_nxt;
      irq <= irq_nxt;
      watchdogReset <= wdr_nxt;
      cmpPin <= pinArr; // [R6]
    end
  end
endmodule

// ### bench/pcc_top_props.sv
module pcc_top_props #(
  parameter int NMOD = 6
) (
  input wire logic            mclk,
  input wire logic            arst_n,
  input wire logic            ce,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [NMOD-1:0] cmpPin,
  input wire logic            irq,
  input wire logic            watchdogReset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce
    |=> wb_ack_o) else $error("request not answered");
  a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_wd_pulse: assert property (watchdogReset && ce |=> !watchdogReset)
    else $error("watchdog pulse too long");
  a_ce_hold: assert property (!ce |=> $stable(cmpPin) && $stable(irq)
    && $stable(wb_ack_o)) else $error("state moved while frozen");
  a_rst_quiet: assert property ($rose(arst_n) |-> !irq
    && !watchdogReset && cmpPin == '0)
    else $error("outputs active after reset");
  a_irq_drop: assert property ($fell(irq) |->
    $past(wb_we_i && wb_stb_i) || $past(wb_we_i && wb_stb_i, 2)
    || $past(wb_we_i && wb_stb_i, 3))
    else $error("interrupt dropped without write");
endmodule
bind pcc_top pcc_top_props #(.NMOD(NMOD)) u_props (.mclk, .arst_n, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .cmpPin, .irq,
  .watchdogReset);

// ### bench/pcc_partner.sv
module pcc_partner (
  input  wire logic mclk,
  output logic      t0Ovf,
  output logic      extCnt,
  output logic      extOsc,
  output logic [5:0] capPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {capPin, extOsc, extCnt, t0Ovf} = '0;
  // Sends n rising edges on line k: 0 timer, 1 count, 2 oscillator, 3+ pins.
  task automatic edges(input int k, input int n);
    repeat (n) begin
      repeat (2) @(posedge mclk);
      {capPin, extOsc, extCnt, t0Ovf} <= 9'h1 << k;
      repeat (2) @(posedge mclk);
      {capPin, extOsc, extCnt, t0Ovf} <= 9'h0;
    end
  endtask
endmodule

// ### bench/pcc_top_tb_top.sv
module pcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, ce, cyc, stb, we, t0, ec, eo, irq, wdr, ack;
  logic [3:0]  adr, sel;
  logic [31:0] dw, dr, v;
  logic [5:0]  cap, cmp;
  logic [15:0] rnd;
  int          n_fail, cmp_count, t, mdl[6];
  int          srcT[3] = '{2, 3, 5};
  int          nT[3] = '{3, 3, 8};
  int          eT[3] = '{3, 3, 1};
  pcc_top dut (.mclk, .arst_n, .ce, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel),
    .wb_dat_o(dr), .wb_ack_o(ack), .t0Ovf(t0), .externalCountInput(ec),
    .extOscClk(eo), .capPin(cap), .cmpPin(cmp), .irq, .watchdogReset(wdr));
  pcc_partner far (.mclk, .t0Ovf(t0), .extCnt(ec), .extOsc(eo),
    .capPin(cap));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
    @(posedge mclk iff ack === 1'b1);
    v = dr;
    {cyc, stb} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end
  initial begin
    {arst_n, ce, cyc, stb, we, adr, dw} = '0;
    sel = 4'hf;
    rnd = 16'h1;
    repeat (5) @(posedge mclk);
    arst_n <= 1;
    ce <= 1;
    bus(0, 4'h0, 0);
    chk(v, 32'h8);
    bus(1, 4'h7, 5);
    bus(0, 4'h1, 0);
    chk(v, 32'h7);
    bus(0, 4'h5, 0);
    chk(v, 32'hffff);
    bus(1, 4'h7, 0);
    bus(1, 4'h1, 7);
    bus(0, 4'h1, 0);
    chk(v, 0);
    for (int m = 6; m >= 0; m--) begin
      bus(1, 4'h1, m);
      bus(0, 4'h1, 0);
      chk(v, m);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1, 4'h0, srcT[i]);
      bus(1, 4'h2, 0);
      bus(1, 4'h0, 8 | srcT[i]);
      far.edges(i, nT[i]);
      repeat (8) @(posedge mclk);
      bus(0, 4'h2, 0);
      chk(v, eT[i]);
    end
    bus(1, 4'h0, 8 | 6);
    bus(0, 4'h0, 0);
    chk(v, 32'hd);
    bus(1, 4'h0, 3);
    bus(1, 4'h2, 32'hffff);
    bus(1, 4'h4, 32'h40);
    bus(1, 4'h0, 32'hb);
    far.edges(1, 1);
    repeat (8) @(posedge mclk);
    chk({31'h0, irq}, 1);
    bus(0, 4'h3, 0);
    chk(v & 32'h40, 32'h40);
    bus(1, 4'h3, 32'h40);
    repeat (3) @(negedge mclk);
    chk({31'h0, irq}, 0);
    bus(1, 4'h7, 1);
    bus(1, 4'h1, 1);
    bus(1, 4'h0, 3);
    bus(1, 4'h2, 32'h1234);
    far.edges(4, 1);
    repeat (8) @(posedge mclk);
    bus(0, 4'h5, 0);
    chk(v, 32'h1234);
    bus(0, 4'h3, 0);
    chk(v & 32'h2, 32'h2);
    bus(1, 4'h1, 0);
    bus(1, 4'h6, 32'h5a);
    bus(0, 4'h2, 0);
    chk(v, 32'h1234);
    bus(1, 4'h6, 32'ha5);
    bus(0, 4'h2, 0);
    chk(v, 0);
    for (int m = 0; m < 5; m++) begin
      rnd = lfsr(rnd);
      mdl[m] = rnd;
      bus(1, 4'h7, m);
      bus(1, 4'h5, rnd);
    end
    for (int m = 0; m < 5; m++) begin
      bus(1, 4'h7, m);
      bus(0, 4'h5, 0);
      chk(v, mdl[m]);
    end
    bus(1, 4'h7, 0);
    bus(1, 4'h5, 32'h0100);
    bus(1, 4'h1, 5);
    bus(1, 4'h2, 32'h0200);
    repeat (4) @(posedge mclk);
    chk({31'h0, cmp[0]}, 1);
    bus(1, 4'h2, 32'h0050);
    repeat (4) @(posedge mclk);
    chk({31'h0, cmp[0]}, 0);
    bus(1, 4'h1, 4);
    repeat (4) @(posedge mclk);
    chk({31'h0, cmp[0]}, 1);
    bus(1, 4'h5, 32'h0050);
    bus(1, 4'h1, 3);
    bus(1, 4'h3, 32'h7f);
    bus(1, 4'h0, 32'hb);
    far.edges(1, 1);
    repeat (8) @(posedge mclk);
    chk({31'h0, cmp[0]}, 0);
    bus(0, 4'h3, 0);
    chk(v & 32'h1, 32'h1);
    bus(1, 4'h0, 3);
    bus(1, 4'h1, 0);
    bus(1, 4'h9, 32'h1234);
    bus(0, 4'h9, 0);
    chk(v, 0);
    bus(1, 4'h2, 32'hfff0);
    bus(1, 4'h0, 8 | 4);
    t = 0;
    while (wdr !== 1'b1 && t < 100) begin
      @(negedge mclk);
      t++;
    end
    chk({31'h0, wdr}, 1);
    @(posedge mclk);
    ce <= 0;
    repeat (6) @(posedge mclk);
    ce <= 1;
    repeat (2) @(posedge mclk);
    arst_n <= 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1;
    bus(0, 4'h0, 0);
    chk(v, 32'h8);
    bus(1, 4'h7, 5);
    bus(0, 4'h1, 0);
    chk(v, 32'h7);
    final_report();
  end
endmodule
